// ### tb/e1_alarm_perf_monitor_event_logic_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "e1_event_regs.svh"
// ----------------------------------------
// port-level checks, bound to the top
// ----------------------------------------
module e1_event_sva #(parameter int NCH = 8) (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [NCH-1:0] counter_snapshot_pulse,
  input wire logic int_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // both write halves taken with no answer pending
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid;
  endsequence
  // read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  rd_latency_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or address still open");
  rd_hi_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("reserved read bits not zero");
  rd_unmapped_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] > 8'hC6 |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  wr_resp_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  aw_block_a: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted too early");
  wr_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("mapped write answered with error");
  // a snapshot strobe never stretches over two cycles
  snap_single_a: assert property (
    counter_snapshot_pulse != 0 |=>
      (counter_snapshot_pulse & $past(counter_snapshot_pulse)) == 0)
    else $error("snapshot strobe longer than one cycle");
  // flags only drop by a software write, so release follows a response
  int_rise_a: assert property ($rose(int_n) |-> $past(s_axi_bvalid))
    else $error("interrupt released without a write");
endmodule
`default_nettype wire

// ### tb/tb_e1_alarm_perf_monitor_event_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "e1_event_regs.svh"
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_e1_alarm_perf_monitor_event_logic;
  localparam int RC = 20; // short red persistence keeps the run brief
  localparam int SC = 50; // short snapshot period
  logic clk, srst, awv, wv, brdy, bv, arv, rrdy, rv, int_n;
  logic awr, wrdy, arr;
  logic [12:0] awa, ara;
  logic [31:0] wd, rdat, rd_v;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [7:0] lost, wstb, few, astb, aval, sstb, szero, tais, mrai, snap;
  logic [71:0] wrap;
  int n_mismatch = 0, compares = 0, cyc = 0, n_snap = 0, s0;
  e1_alarm_perf_monitor_event_logic #(.NCH(8), .RED_CYCLES(RC),
    .SEC_CYCLES(SC)) u_e1_alarm_perf_monitor_event_logic (
    .clk(clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .sync_lost(lost), .win_stb(wstb), .win_few_zeros(few),
    .a_bit_stb(astb), .a_bit_val(aval), .slot16_stb(sstb),
    .slot16_zero(szero), .slot16_ais_state(tais),
    .mf_remote_alarm_state(mrai), .ovf_wrap(wrap),
    .counter_snapshot_pulse(snap), .int_n(int_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bready stays high, so the answer is taken where it is seen
  task automatic wr(input int ch, input logic [7:0] idx,
    input logic [7:0] d);
    logic done;
    done = 1'b0;
    awa <= {ch[2:0], idx, 2'h0};
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) begin
        done = 1'b1;
        wr_r = bresp;
      end
    end
  endtask
  task automatic rd(input int ch, input logic [7:0] idx);
    ara <= {ch[2:0], idx, 2'h0};
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rd_v = rdat;
    rd_r = rresp;
  endtask
  task automatic rc(input int ch, input logic [7:0] idx,
    input logic [31:0] exp);
    rd(ch, idx);
    chk(rd_v, exp);
  endtask
  // one status bit of a channel
  task automatic st(input int ch, input int b, input logic exp);
    rd(ch, 8'hB9);
    chk(rd_v[b], exp);
  endtask
  // one receive event: 0 A bit, 1 window, 2 slot-16 octet
  task automatic ev(input int k, input int ch, input logic v);
    case (k)
      0: begin aval[ch] <= v; astb[ch] <= 1'b1; end
      1: begin few[ch] <= v; wstb[ch] <= 1'b1; end
      default: begin szero[ch] <= v; sstb[ch] <= 1'b1; end
    endcase
    @(posedge clk);
    astb <= 8'h00;
    wstb <= 8'h00;
    sstb <= 8'h00;
    @(posedge clk);
  endtask
  // cycle limit and snapshot count on channel 0
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (snap[0]) n_snap <= n_snap + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      close_out;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1; awv = 1'b0; wv = 1'b0; arv = 1'b0; brdy = 1'b1;
    rrdy = 1'b1; awa = 13'h0000; ara = 13'h0000; wd = 32'h00000000;
    {lost, wstb, few, astb, aval, sstb, szero, tais, mrai} = 72'h0;
    wrap = 72'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rc(0, 8'hBB, 0);
    rc(0, 8'hC3, 0);
    rc(0, 8'hC5, 0);
    chk(int_n, 1'b1);
    $display("reset test done");
    wr(3, 8'hC3, 8'hFF);
    rc(3, 8'hC3, 8'hFF);
    rc(4, 8'hC3, 0);
    wr(3, 8'hC4, 8'hFF);
    rc(3, 8'hC4, 1);
    wr(3, 8'hBC, 8'hFF);
    chk(wr_r, `RESP_OKAY);
    rc(3, 8'hBC, 3);
    rd(0, 8'hD0);
    chk(rd_r, `RESP_SLVERR);
    $display("register test done");
    mrai[2] <= 1'b1;
    repeat (3) @(posedge clk);
    rc(2, 8'hBB, 8'h08);
    wr(2, 8'hBB, 8'h00);
    rc(2, 8'hBB, 8'h08);
    wr(2, 8'hBB, 8'h08);
    mrai[2] <= 1'b0;
    repeat (3) @(posedge clk);
    rc(2, 8'hBB, 8'h08);
    wr(2, 8'hBB, 8'h08);
    wr(2, 8'hBA, 8'h10);
    tais[2] <= 1'b1;
    repeat (3) @(posedge clk);
    chk(int_n, 1'b0);
    rc(2, 8'hBB, 8'h10);
    wr(2, 8'hBB, 8'h10);
    repeat (2) @(posedge clk);
    chk(int_n, 1'b1);
    $display("alarm flag test done");
    repeat (3) ev(0, 1, 1'b1);
    st(1, 1, 1'b0);
    ev(0, 1, 1'b1);
    st(1, 1, 1'b1);
    ev(0, 1, 1'b0);
    st(1, 1, 1'b0);
    wr(1, 8'hBC, 8'h01);
    ev(0, 1, 1'b1);
    st(1, 1, 1'b1);
    ev(0, 1, 1'b0);
    st(1, 1, 1'b0);
    rc(1, 8'hBB, 8'h02);
    lost[4] <= 1'b1;
    ev(1, 4, 1'b1);
    st(4, 2, 1'b1);
    ev(1, 4, 1'b0);
    st(4, 2, 1'b0);
    wr(4, 8'hBC, 8'h02);
    ev(1, 4, 1'b1);
    st(4, 2, 1'b0);
    ev(1, 4, 1'b1);
    st(4, 2, 1'b1);
    ev(1, 4, 1'b0);
    st(4, 2, 1'b1);
    ev(1, 4, 1'b0);
    st(4, 2, 1'b0);
    repeat (15) ev(2, 0, 1'b1);
    st(0, 5, 1'b0);
    ev(2, 0, 1'b1);
    st(0, 5, 1'b1);
    $display("detector test done");
    wr(5, 8'hBA, 8'h01);
    lost[5] <= 1'b1;
    repeat (RC - 8) @(posedge clk);
    st(5, 0, 1'b0);
    repeat (12) @(posedge clk);
    st(5, 0, 1'b1);
    chk(int_n, 1'b0);
    wr(5, 8'hBA, 8'h00);
    repeat (2) @(posedge clk);
    chk(int_n, 1'b1);
    $display("red alarm test done");
    for (int i = 0; i < 9; i++) begin
      wrap[54 + i] <= 1'b1;
      @(posedge clk);
      wrap <= 72'h0;
      @(posedge clk);
      rd(6, (i < 8) ? 8'hC5 : 8'hC6);
      chk(rd_v, (i < 8) ? ((2 << i) - 1) : 1);
    end
    chk(int_n, 1'b1);
    wr(6, 8'hC4, 8'h01);
    repeat (2) @(posedge clk);
    chk(int_n, 1'b0);
    wr(6, 8'hC6, 8'h01);
    repeat (2) @(posedge clk);
    chk(int_n, 1'b1);
    wr(6, 8'hC3, 8'h10);
    repeat (2) @(posedge clk);
    chk(int_n, 1'b0);
    wr(6, 8'hC5, 8'hFF);
    repeat (2) @(posedge clk);
    chk(int_n, 1'b1);
    rc(6, 8'hC5, 0);
    $display("overflow test done");
    s0 = n_snap;
    wr(0, 8'hC2, 8'h02);
    repeat (4) @(posedge clk);
    wr(0, 8'hC2, 8'h02);
    repeat (4) @(posedge clk);
    chk(n_snap - s0, 1);
    wr(0, 8'hC2, 8'h01);
    // one edge lets the new auto bit reach the strobe logic
    @(posedge clk);
    s0 = n_snap;
    repeat (2 * SC) @(posedge clk);
    chk(n_snap - s0, 2);
    wr(0, 8'hC2, 8'h00);
    @(posedge clk);
    s0 = n_snap;
    repeat (2 * SC) @(posedge clk);
    chk(n_snap - s0, 0);
    $display("snapshot test done");
    close_out;
  end
endmodule
bind e1_alarm_perf_monitor_event_logic e1_event_sva #(.NCH(NCH)) u_e1_event_sva (
  .clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .counter_snapshot_pulse(counter_snapshot_pulse), .int_n(int_n));
`default_nettype wire

// ### verilog/alarm_detect.sv
`timescale 1ns/100ps
`default_nettype none
`include "e1_event_regs.svh"
module alarm_detect #(
  parameter int unsigned RED_CYCLES =
    `RED_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ais_crit,      // 0 single window, 1 two windows
  input wire logic rai_crit,      // 0 four ones, 1 single one
  input wire logic sync_lost,     // basic frame sync lost, level
  input wire logic win_stb,       // 512-bit window complete
  input wire logic win_few_zeros, // window held fewer than 3 zeros
  input wire logic a_bit_stb,     // new A bit received
  input wire logic a_bit_val,
  input wire logic slot16_stb,    // new timeslot-16 octet
  input wire logic slot16_zero,   // that octet was all zero
  output logic ais_state,
  output logic rai_state,
  output logic red_state,
  output logic slot16_loss_state
);
  localparam int RW = $clog2(RED_CYCLES + 1);

  generate
    if (RED_CYCLES < 1) begin : g_bad
      $error("red persistence too short");
    end
  endgenerate

  logic prev_few_reg;     // last window result
  logic [2:0] rai_cnt_reg; // run of A bits at one
  logic [RW-1:0] red_cnt_reg;
  logic [4:0] los_cnt_reg;

  // ais: window results, optionally two in a row
  always_ff @(posedge clk) begin
    if (srst) begin
      ais_state <= 1'b0;
      prev_few_reg <= 1'b0;
    end else if (win_stb) begin
      prev_few_reg <= win_few_zeros;
      if (!ais_crit) begin
        if (win_few_zeros && sync_lost) ais_state <= 1'b1;
        else if (!win_few_zeros) ais_state <= 1'b0;
      end else if (win_few_zeros == prev_few_reg) begin
        ais_state <= win_few_zeros;
      end
    end
  end

  // remote alarm: run of ones declares, any zero clears
  always_ff @(posedge clk) begin
    if (srst) begin
      rai_state <= 1'b0;
      rai_cnt_reg <= '0;
    end else if (a_bit_stb) begin
      if (!a_bit_val) begin
        rai_state <= 1'b0;
        rai_cnt_reg <= '0;
      end else begin
        if (rai_cnt_reg != 3'(`RAI_RUN)) rai_cnt_reg <= rai_cnt_reg + 3'd1;
        if (rai_crit || rai_cnt_reg == 3'(`RAI_RUN - 1))
          rai_state <= 1'b1;
      end
    end
  end

  // red: sync condition must disagree for the whole period
  always_ff @(posedge clk) begin
    if (srst) begin
      red_state <= 1'b0;
      red_cnt_reg <= '0;
    end else if (sync_lost == red_state) begin
      red_cnt_reg <= '0;
    end else if (red_cnt_reg == RW'(RED_CYCLES - 1)) begin
      red_state <= sync_lost;
      red_cnt_reg <= '0;
    end else begin
      red_cnt_reg <= red_cnt_reg + RW'(1);
    end
  end

  // slot16 loss: a run of octets that disagree flips the state
  always_ff @(posedge clk) begin
    if (srst) begin
      slot16_loss_state <= 1'b0;
      los_cnt_reg <= '0;
    end else if (slot16_stb) begin
      if (slot16_zero == slot16_loss_state) begin
        los_cnt_reg <= '0;
      end else if (los_cnt_reg == 5'(`SLOT16_RUN - 1)) begin
        slot16_loss_state <= slot16_zero;
        los_cnt_reg <= '0;
      end else begin
        los_cnt_reg <= los_cnt_reg + 5'd1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/e1_alarm_perf_monitor_event_logic.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "e1_event_regs.svh"
module e1_alarm_perf_monitor_event_logic #(
  parameter int NCH = `NUM_CHAN,
  parameter int unsigned RED_CYCLES =
    `RED_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS,
  parameter int unsigned SEC_CYCLES =
    `SNAP_PERIOD_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic srst,
  // axi4-lite slave
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // receive-side events, one bit per channel
  input wire logic [NCH-1:0] sync_lost,
  input wire logic [NCH-1:0] win_stb,
  input wire logic [NCH-1:0] win_few_zeros,
  input wire logic [NCH-1:0] a_bit_stb,
  input wire logic [NCH-1:0] a_bit_val,
  input wire logic [NCH-1:0] slot16_stb,
  input wire logic [NCH-1:0] slot16_zero,
  input wire logic [NCH-1:0] slot16_ais_state,
  input wire logic [NCH-1:0] mf_remote_alarm_state,
  // counter wrap pulses, 9 per channel, channel n at [9n+8:9n]
  input wire logic [NCH*`OVF_W-1:0] ovf_wrap,
  // outputs
  output logic [NCH-1:0] counter_snapshot_pulse,
  output logic int_n
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (NCH < 1 || NCH > `NUM_CHAN) begin : g_bad_nch
      $error("channel count must be 1 to 8");
    end
  endgenerate

  // ----------------------------------------
  // per-channel register storage
  // ----------------------------------------
  e1_event_pkg::alarm_vec_t alm_flag_reg [NCH]; // change flags
  e1_event_pkg::alarm_vec_t alm_en_reg [NCH];   // change enables
  e1_event_pkg::alarm_vec_t alm_prev_reg [NCH]; // last status
  e1_event_pkg::alarm_vec_t alm_stat [NCH];     // live status
  e1_event_pkg::ovf_vec_t ovf_flag_reg [NCH];   // b8 = line code
  e1_event_pkg::ovf_vec_t ovf_en_reg [NCH];     // b8 = enable b
  logic [1:0] crit_reg [NCH];  // ais and remote criteria
  logic [1:0] snap_reg [NCH];  // manual and auto control
  logic [NCH-1:0] ais_st;
  logic [NCH-1:0] rai_st;
  logic [NCH-1:0] red_st;
  logic [NCH-1:0] los_st;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic [`ADDR_W-1:0] aw_addr_reg; // held write address
  logic aw_hold_reg;               // address captured
  logic [7:0] w_data_reg;          // low byte only is backed
  logic w_lane0_reg;               // byte lane 0 enabled
  logic w_hold_reg;                // data captured
  logic wr_fire;                   // both halves present
  logic [2:0] wr_chan;
  logic [7:0] wr_idx;
  logic wr_hit;

  // a write is performed once both halves are in and the
  // previous response has drained
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_chan = aw_addr_reg[2+`CHAN_SHIFT +: 3];
  assign wr_idx = aw_addr_reg[2 +: 8];

  // address half: ready drops while held
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // data half: independent of the address, either may come first
  always_ff @(posedge clk) begin
    if (srst) begin
      w_hold_reg <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_reg <= '0;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_reg <= s_axi_wdata[7:0];
      w_lane0_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // decode of the held write address
  always_comb begin
    wr_hit = 1'b0;
    if (int'(wr_chan) < NCH) begin
      unique case (wr_idx)
        `IDX_ALM_STATUS, `IDX_ALM_ENABLE, `IDX_ALM_FLAGS,
        `IDX_CRITERIA, `IDX_SNAP_CTRL, `IDX_OVF_EN_A,
        `IDX_OVF_EN_B, `IDX_OVF_FLAGS_A, `IDX_OVF_FLAGS_B:
          wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
    end
  end

  // response: unmapped addresses answer slverr and store nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic [2:0] rd_chan;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign rd_chan = s_axi_araddr[2+`CHAN_SHIFT +: 3];
  assign rd_idx = s_axi_araddr[2 +: 8];

  // read mux; unbacked bits come back as zero
  always_comb begin
    rd_byte = '0;
    rd_hit = 1'b0;
    if (int'(rd_chan) < NCH) begin
      rd_hit = 1'b1;
      unique case (rd_idx)
        `IDX_ALM_STATUS: rd_byte = {2'b00, alm_stat[rd_chan]};
        `IDX_ALM_ENABLE: rd_byte = {2'b00, alm_en_reg[rd_chan]};
        `IDX_ALM_FLAGS: rd_byte = {2'b00, alm_flag_reg[rd_chan]};
        `IDX_CRITERIA: rd_byte = {6'b0, crit_reg[rd_chan]};
        `IDX_SNAP_CTRL: rd_byte = {6'b0, snap_reg[rd_chan]};
        `IDX_OVF_EN_A: rd_byte = ovf_en_reg[rd_chan][7:0];
        `IDX_OVF_EN_B:
          rd_byte = {7'b0, ovf_en_reg[rd_chan][`OVF_B_BIT]};
        `IDX_OVF_FLAGS_A: rd_byte = ovf_flag_reg[rd_chan][7:0];
        `IDX_OVF_FLAGS_B:
          rd_byte = {7'b0, ovf_flag_reg[rd_chan][`OVF_B_BIT]};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // one read in flight; data is registered at the address edge
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'b0, rd_byte};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // snapshot triggers
  // ----------------------------------------
  snap_if #(.NCH(NCH)) snap ();

  snapshot_timer #(.SEC_CYCLES(SEC_CYCLES)) u_snap (
    .clk(clk),
    .srst(srst),
    .sif(snap.timer)
  );

  assign counter_snapshot_pulse = snap.pulse;

  // ----------------------------------------
  // per-channel logic
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      logic wsel; // this channel addressed by the write
      logic [`ALM_W-1:0] alm_clr;
      logic [`OVF_W-1:0] ovf_clr;
      logic [`OVF_W-1:0] wrap;

      assign wsel = wr_fire && w_lane0_reg && (int'(wr_chan) == ch);
      assign wrap = ovf_wrap[ch*`OVF_W +: `OVF_W];
      // only ones written clear a flag
      assign alm_clr = (wsel && wr_idx == `IDX_ALM_FLAGS) ?
        w_data_reg[`ALM_W-1:0] : '0;
      assign ovf_clr = {
        (wsel && wr_idx == `IDX_OVF_FLAGS_B) & w_data_reg[0],
        (wsel && wr_idx == `IDX_OVF_FLAGS_A) ?
          w_data_reg : 8'h00};

      assign snap.manual_bit[ch] = snap_reg[ch][`SNAP_MAN_BIT];
      assign snap.auto_bit[ch] = snap_reg[ch][`SNAP_AUTO_BIT];

      alarm_detect #(.RED_CYCLES(RED_CYCLES)) u_det (
        .clk(clk),
        .srst(srst),
        .ais_crit(crit_reg[ch][`CRIT_AIS_BIT]),
        .rai_crit(crit_reg[ch][`CRIT_RAI_BIT]),
        .sync_lost(sync_lost[ch]),
        .win_stb(win_stb[ch]),
        .win_few_zeros(win_few_zeros[ch]),
        .a_bit_stb(a_bit_stb[ch]),
        .a_bit_val(a_bit_val[ch]),
        .slot16_stb(slot16_stb[ch]),
        .slot16_zero(slot16_zero[ch]),
        .ais_state(ais_st[ch]),
        .rai_state(rai_st[ch]),
        .red_state(red_st[ch]),
        .slot16_loss_state(los_st[ch])
      );

      // status in flag order: b5 loss, b4 ais16, b3 mf, b2..b0
      assign alm_stat[ch] = {los_st[ch], slot16_ais_state[ch],
        mf_remote_alarm_state[ch], ais_st[ch], rai_st[ch],
        red_st[ch]};

      // change flags: an edge in the same cycle as a clear wins
      always_ff @(posedge clk) begin
        if (srst) begin
          alm_prev_reg[ch] <= '0;
          alm_flag_reg[ch] <= '0;
        end else begin
          alm_prev_reg[ch] <= alm_stat[ch];
          alm_flag_reg[ch] <= (alm_flag_reg[ch] & ~alm_clr)
            | (alm_stat[ch] ^ alm_prev_reg[ch]);
        end
      end

      // overflow flags: wraps set, b4 is the sequence error count
      always_ff @(posedge clk) begin
        if (srst) begin
          ovf_flag_reg[ch] <= '0;
        end else begin
          ovf_flag_reg[ch] <= (ovf_flag_reg[ch] & ~ovf_clr)
            | wrap;
        end
      end

      // plain control registers; unbacked bits are dropped
      always_ff @(posedge clk) begin
        if (srst) begin
          alm_en_reg[ch] <= '0;
          ovf_en_reg[ch] <= '0;
          crit_reg[ch] <= '0;
          snap_reg[ch] <= '0;
        end else if (wsel) begin
          unique case (wr_idx)
            `IDX_ALM_ENABLE: alm_en_reg[ch] <= w_data_reg[5:0];
            `IDX_CRITERIA: crit_reg[ch] <= w_data_reg[1:0];
            `IDX_SNAP_CTRL: snap_reg[ch] <= w_data_reg[1:0];
            `IDX_OVF_EN_A: ovf_en_reg[ch][7:0] <= w_data_reg;
            `IDX_OVF_EN_B:
              ovf_en_reg[ch][`OVF_B_BIT] <= w_data_reg[0];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // shared interrupt output
  // ----------------------------------------
  logic pend; // any enabled flag in any channel

  // registered, so the pin lags the flag by one cycle
  always_comb begin
    pend = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      pend = pend | (|(alm_flag_reg[i] & alm_en_reg[i]))
        | (|(ovf_flag_reg[i][7:0] & ovf_en_reg[i][7:0]))
        | (ovf_flag_reg[i][`OVF_B_BIT]
           & ovf_en_reg[i][`OVF_B_BIT]);
    end
  end

  // active low pin straight from a flop, so it never glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !pend;
    end
  end
endmodule
`default_nettype wire

// ### verilog/e1_event_pkg.sv
`default_nettype none
package e1_event_pkg;
  // one channel's alarm status or change flags, b5..b0
  typedef logic [5:0] alarm_vec_t;
  // overflow flags, b8 is the line code counter
  typedef logic [8:0] ovf_vec_t;
  // register byte as seen on the bus
  typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

// ### verilog/e1_event_regs.svh
`ifndef E1_EVENT_REGS_SVH
`define E1_EVENT_REGS_SVH

// ----------------------------------------
// register indexes (byte address = 4 x index)
// ----------------------------------------
`define IDX_ALM_STATUS 8'hB9
`define IDX_ALM_ENABLE 8'hBA
`define IDX_ALM_FLAGS 8'hBB
`define IDX_CRITERIA 8'hBC
`define IDX_SNAP_CTRL 8'hC2
`define IDX_OVF_EN_A 8'hC3
`define IDX_OVF_EN_B 8'hC4
`define IDX_OVF_FLAGS_A 8'hC5
`define IDX_OVF_FLAGS_B 8'hC6
`define CHAN_SHIFT 8
`define ADDR_W 13
`define NUM_CHAN 8

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define ALM_W 6
`define OVF_A_W 8
`define OVF_W 9
`define OVF_B_BIT 8
`define SEQ_ERR_BIT 4
`define CRIT_AIS_BIT 1
`define CRIT_RAI_BIT 0
`define SNAP_MAN_BIT 1
`define SNAP_AUTO_BIT 0

// ----------------------------------------
// timing and detector counts
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define RED_TIME_MS 100
`define SNAP_PERIOD_MS 1000
`define NS_PER_MS 1000000
`define SLOT16_RUN 16
`define RAI_RUN 4

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verilog/snap_if.sv
`timescale 1ns/100ps
`default_nettype none
// control bits in, snapshot strobes out, per channel
interface snap_if #(parameter int NCH = 8);
  logic [NCH-1:0] manual_bit; // software manual trigger bit
  logic [NCH-1:0] auto_bit;   // software automatic enable bit
  logic [NCH-1:0] pulse;      // one-cycle snapshot strobe
  modport ctrl (output manual_bit, output auto_bit, input pulse);
  modport timer (input manual_bit, input auto_bit, output pulse);
endinterface
`default_nettype wire

// ### verilog/snapshot_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "e1_event_regs.svh"
module snapshot_timer #(
  parameter int unsigned SEC_CYCLES =
    `SNAP_PERIOD_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic srst,
  snap_if.timer sif
);
  localparam int CW = $clog2(SEC_CYCLES + 1);

  generate
    if (SEC_CYCLES < 2) begin : g_bad
      $error("snapshot period too short");
    end
  endgenerate

  // ----------------------------------------
  // shared one-second tick
  // ----------------------------------------
  logic [CW-1:0] sec_cnt_reg; // free running, one tick per wrap
  logic [$bits(sif.pulse)-1:0] man_prev_reg; // for edge detect
  logic tick;

  assign tick = (sec_cnt_reg == CW'(SEC_CYCLES - 1));

  // one counter serves every channel; all auto-enabled channels refresh together
  always_ff @(posedge clk) begin
    if (srst || tick) begin
      sec_cnt_reg <= '0;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + CW'(1);
    end
  end

  // ----------------------------------------
  // strobes: manual rise or auto tick
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      man_prev_reg <= '0;
      sif.pulse <= '0;
    end else begin
      man_prev_reg <= sif.manual_bit;
      sif.pulse <= (sif.manual_bit & ~man_prev_reg)
        | ({$bits(sif.pulse){tick}} & sif.auto_bit);
    end
  end
endmodule
`default_nettype wire
